// File: design/led_drive_if.sv
// carrier between the register core and the indicator pin driver
// assumes both ends share ref_clk_in
`timescale 1ns/10ps
interface led_drive_if;
   import plc_pkg::*;
   led_mode_type led_mode;
   logic debug_mode;
   logic link;
   logic speed100;
   logic full_duplex;
   logic activity;
   logic stretched_energy;
   logic device_ready;
   logic pin_zero_d;
   logic pin_one_d;
   modport core (output led_mode, debug_mode, link, speed100, full_duplex, activity, stretched_energy,
      device_ready, input pin_zero_d, pin_one_d);
   modport drive (input led_mode, debug_mode, link, speed100, full_duplex, activity, stretched_energy,
      device_ready, output pin_zero_d, pin_one_d);
endinterface

// File: design/led_indicator_drive.sv
// next value of both indicator pins, normal or debug
// assumes the core registers the pin values; blink flop frozen with clk_en_in
`timescale 1ns/10ps
module led_indicator_drive
   import plc_pkg::*;
#(
   parameter int BLINK_BITS = 20
) (
   input wire logic ref_clk_in, // core clock
   input wire logic reset_in, // synchronous, active high
   input wire logic clk_en_in, // freezes state when low
   led_drive_if.drive led // modes in, pin values out
);
   logic [BLINK_BITS-1:0] blink_q;
   logic blink;
   logic link_n;
   logic link_act_n;
   logic act_n;
   logic speed_n;
   logic duplex_n;
   logic norm_zero;
   logic norm_one;

   // free blink divider so activity shows as a visible toggle
   always_ff @(posedge ref_clk_in) begin
      if (reset_in)
         blink_q <= '0;
      else if (clk_en_in)
         blink_q <= blink_q + 1'b1;
   end

   assign blink = blink_q[BLINK_BITS-1];
   assign link_n = ~led.link;
   assign act_n = led.activity ? blink : 1'b1;
   assign link_act_n = link_n | (led.activity & blink);
   assign speed_n = ~(led.link & led.speed100);
   assign duplex_n = ~(led.link & led.full_duplex);
   assign norm_zero = (led.led_mode == led_link_act || led.led_mode == led_link_duplex) ? link_n : link_act_n;
   assign norm_one = (led.led_mode == led_linkact_speed) ? speed_n :
                     (led.led_mode == led_link_act) ? act_n : duplex_n;
   assign led.pin_zero_d = led.debug_mode ? ~led.device_ready : norm_zero;
   assign led.pin_one_d = led.debug_mode ? ~led.stretched_energy : norm_one;
endmodule

// File: design/plc_pkg.sv
// types shared by the power/led/host configuration block
// assumes nothing beyond a SystemVerilog compiler
package plc_pkg;
   typedef enum logic [1:0] {
      host_i2c_master,
      host_i2c_slave,
      host_spi_slave,
      host_serial_management_port
   } host_mode_type;
   typedef enum logic [1:0] {
      led_linkact_speed,
      led_link_act,
      led_linkact_duplex,
      led_link_duplex
   } led_mode_type;
endpackage

// File: design/plc_regs.svh
// register offsets, field positions, reset values and timing for the power/led/host block
// assumes an 8-bit register address space and 8-bit data
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
`define PMC_ADDR 8'hc3
`define SLEEP_ADDR 8'hc4
`define VIDHOST_ADDR 8'hc6
`define PMC_CPU_PD_BIT 7
`define PMC_SW_PD_BIT 6
`define PMC_LED_MODE_HI 5
`define PMC_LED_MODE_LO 4
`define PMC_LED_OUT_BIT 3
`define PMC_PLL_OFF_BIT 2
`define PMC_PM_MODE_HI 1
`define PMC_PM_MODE_LO 0
`define PMC_RESET 8'h00
`define PM_MODE_ENERGY 2'h1
`define SLEEP_RESET 8'h50
`define VID_PORTS_HI 6
`define VID_PORTS_LO 4
`define VID_PORTS_RESET 3'h0
`define HOST_MODE_HI 1
`define HOST_MODE_LO 0
`define CLK_PERIOD_NS 40
`define SLEEP_UNIT_NS 20000000
`define SLEEP_UNIT_CYCLES (`SLEEP_UNIT_NS / `CLK_PERIOD_NS)
`endif

// File: design/power_led_host_mode_config.sv
// power saving, indicator pin and host interface mode configuration registers
// assumes an 8-bit register port from the management interface logic on the same clock,
// strap pins and the no-energy flag arrive asynchronously, link status comes from same-clock logic
`timescale 1ns/10ps
`include "plc_regs.svh"
module power_led_host_mode_config
   import plc_pkg::*;
#(
   parameter int SLEEP_UNIT = `SLEEP_UNIT_CYCLES
) (
   input wire logic ref_clk_in, // 25 MHz core clock
   input wire logic reset_in, // synchronous, active high, hold 4+ cycles
   input wire logic clk_en_in, // freezes state when low
   input wire logic [7:0] reg_addr_in, // register address
   input wire logic reg_wr_in, // one-cycle write strobe
   input wire logic reg_rd_in, // one-cycle read strobe
   input wire logic [7:0] reg_wdata_in, // write data
   output logic [7:0] reg_rdata_out, // read data, valid cycle after strobe
   input wire logic port_two_indicator_strap_high_in, // strap pin, async
   input wire logic port_two_indicator_strap_low_in, // strap pin, async
   input wire logic no_energy_in, // analog no-energy flag, async
   input wire logic stretched_energy_in, // analog stretched energy, same clock
   input wire logic device_ready_in, // internal device ready
   input wire logic link_in, // link up
   input wire logic speed100_in, // 100 Mbit link
   input wire logic full_duplex_in, // full duplex link
   input wire logic activity_in, // frame activity
   output logic indicator_pin_zero_out, // first led pin
   output logic indicator_pin_one_out, // second led pin
   output logic low_power_out, // device in low power state
   output logic pll_power_down_out, // pll power-down enable
   output logic [2:0] invalid_vid_ports_out, // forward ports for invalid VID
   output host_mode_type host_mode_out // host interface mode
);
   logic [7:0] pmc_q;
   logic [7:0] sleep_q;
   logic [2:0] vid_ports_q;
   host_mode_type host_mode_q;
   logic [2:0] strap_hi_s;
   logic [2:0] strap_lo_s;
   logic [2:0] no_energy_s;
   logic no_energy_q;
   logic [31:0] unit_cnt_q;
   logic [7:0] unit_tot_q;
   logic low_power_q;
   logic pin_zero_q;
   logic pin_one_q;
   logic [7:0] rdata_q;
   logic pmc_wr;
   logic sleep_wr;
   logic vid_wr;
   logic energy_detect_sleep;
   logic unit_done;
   logic [7:0] rdata_d;
   led_drive_if led ();

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   assign pmc_wr = reg_wr_in & hit(reg_addr_in, `PMC_ADDR);
   assign sleep_wr = reg_wr_in & hit(reg_addr_in, `SLEEP_ADDR);
   assign vid_wr = reg_wr_in & hit(reg_addr_in, `VIDHOST_ADDR);
   assign energy_detect_sleep = pmc_q[`PMC_PM_MODE_HI:`PMC_PM_MODE_LO] == `PM_MODE_ENERGY;
   assign unit_done = unit_cnt_q == SLEEP_UNIT - 1;
   // reserved bit and the unimplemented clock-source bits read as zero
   assign rdata_d = hit(reg_addr_in, `PMC_ADDR) ? pmc_q :
                    hit(reg_addr_in, `SLEEP_ADDR) ? sleep_q :
                    hit(reg_addr_in, `VIDHOST_ADDR) ? {1'b0, vid_ports_q, 2'b00, host_mode_q} : 8'h00;

   // three-stage synchronisers; stages not reset so straps are valid during reset
   always_ff @(posedge ref_clk_in) begin
      if (clk_en_in || reset_in) begin
         strap_hi_s <= {strap_hi_s[1:0], port_two_indicator_strap_high_in};
         strap_lo_s <= {strap_lo_s[1:0], port_two_indicator_strap_low_in};
         no_energy_s <= {no_energy_s[1:0], no_energy_in};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in)
         no_energy_q <= 1'b0;
      else if (clk_en_in && no_energy_s[1] == no_energy_s[2])
         no_energy_q <= no_energy_s[2];
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pmc_q <= `PMC_RESET;
         sleep_q <= `SLEEP_RESET;
         vid_ports_q <= `VID_PORTS_RESET;
      end else if (clk_en_in) begin
         if (pmc_wr)
            pmc_q <= reg_wdata_in;
         if (sleep_wr)
            sleep_q <= reg_wdata_in;
         if (vid_wr)
            vid_ports_q <= reg_wdata_in[`VID_PORTS_HI:`VID_PORTS_LO];
      end
   end

   // strap level taken every reset cycle, last value before release wins
   always_ff @(posedge ref_clk_in) begin
      if (reset_in)
         host_mode_q <= host_mode_type'({strap_hi_s[2], strap_lo_s[2]});
      else if (clk_en_in && vid_wr)
         host_mode_q <= host_mode_type'(reg_wdata_in[`HOST_MODE_HI:`HOST_MODE_LO]);
   end

   // consecutive no-energy time in 20 ms units; energy lasting two or more cycles restarts it
   always_ff @(posedge ref_clk_in) begin
      if (reset_in || (clk_en_in && (!energy_detect_sleep || !no_energy_q))) begin
         unit_cnt_q <= '0;
         unit_tot_q <= '0;
      end else if (clk_en_in) begin
         unit_cnt_q <= unit_done ? '0 : unit_cnt_q + 1'b1;
         if (unit_done && unit_tot_q != 8'hff)
            unit_tot_q <= unit_tot_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in)
         low_power_q <= 1'b0;
      else if (clk_en_in)
         low_power_q <= energy_detect_sleep && no_energy_q && unit_tot_q >= sleep_q;
   end

   assign led.led_mode = led_mode_type'(pmc_q[`PMC_LED_MODE_HI:`PMC_LED_MODE_LO]);
   assign led.debug_mode = pmc_q[`PMC_LED_OUT_BIT];
   assign led.link = link_in;
   assign led.speed100 = speed100_in;
   assign led.full_duplex = full_duplex_in;
   assign led.activity = activity_in;
   assign led.stretched_energy = stretched_energy_in;
   assign led.device_ready = device_ready_in;

   led_indicator_drive u_led (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .clk_en_in(clk_en_in),
      .led(led)
   );

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pin_zero_q <= 1'b1;
         pin_one_q <= 1'b1;
         rdata_q <= 8'h00;
      end else if (clk_en_in) begin
         pin_zero_q <= led.pin_zero_d;
         pin_one_q <= led.pin_one_d;
         if (reg_rd_in)
            rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign indicator_pin_zero_out = pin_zero_q;
   assign indicator_pin_one_out = pin_one_q;
   assign low_power_out = low_power_q;
   // pll off only matters to software paired with energy detect mode
   assign pll_power_down_out = pmc_q[`PMC_PLL_OFF_BIT];
   assign invalid_vid_ports_out = vid_ports_q;
   assign host_mode_out = host_mode_q;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   sequence pmc_write_s;
      clk_en_in && pmc_wr;
   endsequence

   sleep_reset_a: assert property ($fell(reset_in) |-> sleep_q == `SLEEP_RESET)
      else $error("sleep threshold not at reset value");
   pll_write_a: assert property (pmc_write_s |=> pll_power_down_out == $past(reg_wdata_in[`PMC_PLL_OFF_BIT]))
      else $error("pll off bit did not follow write");
   pll_reset_a: assert property ($fell(reset_in) |-> !pll_power_down_out)
      else $error("pll off not clear after reset");
   debug_pin_one_a: assert property (clk_en_in && led.debug_mode |=>
      indicator_pin_one_out == !$past(stretched_energy_in))
      else $error("debug pin one wrong");
   debug_pin_zero_a: assert property (clk_en_in && led.debug_mode |=>
      indicator_pin_zero_out == !$past(device_ready_in))
      else $error("debug pin zero wrong");
   vid_write_a: assert property (clk_en_in && vid_wr |=>
      invalid_vid_ports_out == $past(reg_wdata_in[`VID_PORTS_HI:`VID_PORTS_LO]))
      else $error("invalid vid ports did not follow write");
   reserved_read_a: assert property (clk_en_in && reg_rd_in && hit(reg_addr_in, `VIDHOST_ADDR) |=>
      !reg_rdata_out[7])
      else $error("reserved bit read as one");
   host_strap_a: assert property ($fell(reset_in) |->
      host_mode_out == host_mode_type'({$past(strap_hi_s[2]), $past(strap_lo_s[2])}))
      else $error("host mode not loaded from straps");
   // threshold and mode as they stood when the decision was registered
   sleep_entry_a: assert property ($rose(low_power_out) |->
      $past(energy_detect_sleep) && $past(unit_tot_q) >= $past(sleep_q))
      else $error("low power entered early");
   sleep_exit_a: assert property (clk_en_in && low_power_out && !no_energy_q |=> !low_power_out)
      else $error("low power held after energy returned");
   vid_reset_a: assert property ($fell(reset_in) |-> invalid_vid_ports_out == `VID_PORTS_RESET)
      else $error("invalid vid ports not clear after reset");
   // a low enable must leave the pmc and sleep registers and the sleep state untouched
   frozen_hold_a: assert property (!clk_en_in |=>
      $stable(pmc_q) && $stable(sleep_q) && $stable(low_power_out))
      else $error("state moved while clock enable low");
   link_normal_a: assert property (clk_en_in && !led.debug_mode && !link_in |=> indicator_pin_zero_out)
      else $error("pin zero low without link");
endmodule

// File: tb/mgmt_host.sv
// management processor model driving the 8-bit register port
// assumes the bench calls wr_reg and rd_reg; signals move only at rising edges
`timescale 1ns/10ps
module mgmt_host (
   input wire logic ref_clk_in, // core clock
   output logic [7:0] reg_addr_out, // register address
   output logic reg_wr_out, // write strobe
   output logic reg_rd_out, // read strobe
   output logic [7:0] reg_wdata_out, // write data
   input wire logic [7:0] reg_rdata_in // read data
);
   initial begin
      reg_addr_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = 8'h00;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'hc6) v[7] = 1'b0;
      if (a == 8'hc3 && v[1:0] != 2'h1) v[2] = 1'b0;
      @(posedge ref_clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= v;
      reg_wr_out <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_out <= 1'b0;
      // data not held past the strobe, so stale values cannot pass
      reg_wdata_out <= ~v;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_out <= 1'b0;
      @(negedge ref_clk_in);
      d = reg_rdata_in;
   endtask
endmodule

// File: tb/tb_top.sv
// bench for the power, indicator and host mode configuration block
// assumes mgmt_host drives the register port; expectations come from a shadow model
`timescale 1ns/10ps
module tb_top;
   import plc_pkg::*;
   localparam int UNIT = 4;
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [7:0] addr, wdata, rdata, got;
   logic wr, rd, pin0, pin1, lp, pll;
   logic s_hi = 1'b0, s_lo = 1'b0, no_en = 1'b0, str = 1'b0, rdy = 1'b0;
   logic link = 1'b0, spd = 1'b0, dup = 1'b0;
   logic en = 1'b1, act = 1'b0;
   logic [2:0] vid;
   host_mode_type mode;
   logic [31:0] seed = 32'h5d05f880;
   int regs [int];
   int fail_count = 0;
   int samples_checked = 0;
   always #20 ref_clk_in = ~ref_clk_in;
   mgmt_host u_host (.ref_clk_in(ref_clk_in), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_wdata_out(wdata), .reg_rdata_in(rdata));
   power_led_host_mode_config #(.SLEEP_UNIT(UNIT)) u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .clk_en_in(en), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .port_two_indicator_strap_high_in(s_hi), .port_two_indicator_strap_low_in(s_lo),
      .no_energy_in(no_en), .stretched_energy_in(str), .device_ready_in(rdy), .link_in(link),
      .speed100_in(spd), .full_duplex_in(dup), .activity_in(act), .indicator_pin_zero_out(pin0),
      .indicator_pin_one_out(pin1), .low_power_out(lp), .pll_power_down_out(pll),
      .invalid_vid_ports_out(vid), .host_mode_out(mode));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic close_out();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task automatic do_reset(input logic [1:0] s);
      @(posedge ref_clk_in);
      reset_in <= 1'b1;
      s_hi <= s[1];
      s_lo <= s[0];
      cyc(20);
      reset_in <= 1'b0;
      regs.delete();
      regs[8'hc3] = 0;
      regs[8'hc4] = 8'h50;
      regs[8'hc6] = s;
   endtask
   task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
      u_host.wr_reg(a, d);
      if (regs.exists(a)) regs[a] = (a == 8'hc6) ? (d & 8'h73) : d;
   endtask
   task automatic rd_chk(input logic [7:0] a);
      u_host.rd_reg(a, got);
      check(got, regs.exists(a) ? 8'(regs[a]) : 8'h00);
   endtask
   task automatic wait_lp(input logic v, input int lim, output int n);
      n = 0;
      while (lp !== v && n < lim) begin
         @(negedge ref_clk_in);
         n++;
      end
      if (lp !== v) begin
         fail_count++;
         close_out();
      end
   endtask
   task automatic drive(input logic [7:0] d);
      @(posedge ref_clk_in);
      rdy <= d[0];
      str <= d[1];
      link <= d[2];
      spd <= d[3];
      dup <= d[4];
      act <= d[5];
      cyc(2);
      @(negedge ref_clk_in);
   endtask
   initial begin
      logic [7:0] d;
      int n;
      for (int s = 0; s < 4; s++) begin
         do_reset(2'(s));
         @(negedge ref_clk_in);
         check({6'h0, mode}, 8'(s));
         check({5'h0, vid, pll}, 8'h00);
         rd_chk(8'hc6);
      end
      rd_chk(8'hc4);
      rd_chk(8'hc3);
      // write with the enable low must be ignored
      en <= 1'b0;
      u_host.wr_reg(8'hc4, 8'h11);
      en <= 1'b1;
      rd_chk(8'hc4);
      for (int i = 0; i < 6; i++) begin
         d = 8'(rnd());
         wr_m(8'hc6, d);
         @(negedge ref_clk_in);
         check({5'h0, vid}, {5'h0, d[6:4]});
         check({6'h0, mode}, {6'h0, d[1:0]});
         rd_chk(8'hc6);
         wr_m(8'hc4, d);
         wr_m(8'hc5, ~d);
         rd_chk(8'hc4);
         rd_chk(8'(rnd()));
      end
      // pll off only together with energy detect mode
      wr_m(8'hc3, 8'h05);
      @(negedge ref_clk_in);
      check({7'h0, pll}, 8'h01);
      for (int k = 0; k < 2; k++) begin
         wr_m(8'hc4, 8'(k * 3));
         cyc(1);
         no_en <= 1'b1;
         cyc(8);
         no_en <= 1'b0;
         cyc(8);
         no_en <= 1'b1;
         wait_lp(1'b1, 100, n);
         check(8'(n >= k * 3 * UNIT + 2 && n <= k * 3 * UNIT + 8), 8'h01);
         @(posedge ref_clk_in);
         no_en <= 1'b0;
         wait_lp(1'b0, 10, n);
      end
      wr_m(8'hc3, 8'h00);
      no_en <= 1'b1;
      cyc(30);
      @(negedge ref_clk_in);
      check({6'h0, lp, pll}, 8'h00);
      for (int m = 0; m < 5; m++) begin
         wr_m(8'hc3, m == 4 ? 8'h08 : 8'(m << 4));
         repeat (6) begin
            d = 8'(rnd());
            drive(d);
            if (m == 4) begin
               check({7'h0, pin0}, {7'h0, ~d[0]});
               check({7'h0, pin1}, {7'h0, ~d[1]});
            end else begin
               check({7'h0, pin0}, {7'h0, ~d[2]});
               if (d[2] && m != 1) check({7'h0, pin1}, {7'h0, (m == 0) ? ~d[3] : ~d[4]});
               // short run stays in the first blink phase, so activity shows as on
               if (m == 1) check({7'h0, pin1}, {7'h0, ~d[5]});
            end
         end
      end
      close_out();
   end
endmodule
